// file: logic/byte_fifo.sv
// synchronous fifo with valid/ready on both sides and a flush
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,              // system clock
  input wire logic rst_i,              // synchronous reset, active high
  input wire logic flush_i,            // drop all contents
  input wire logic in_valid_i,         // write side offers a word
  input wire logic [WIDTH-1:0] in_data_i,  // word offered
  output logic in_ready_o,             // room for a word, registered
  output logic out_valid_o,            // word available, registered
  output logic [WIDTH-1:0] out_data_o, // oldest word
  input wire logic out_ready_i         // read side takes the word
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] count;
    logic full;
    logic empty;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic push;
  logic pop;

  // full and empty are registered so in_ready_o and out_valid_o are clean flops
  always_comb
  begin
    push = in_valid_i && !s.full;
    pop = out_ready_i && !s.empty;
    next_s = s;
    if (push)
      next_s.wr = (s.wr == PW'(DEPTH - 1)) ? '0 : s.wr + PW'(1);
    if (pop)
      next_s.rd = (s.rd == PW'(DEPTH - 1)) ? '0 : s.rd + PW'(1);
    next_s.count = s.count + (PW + 1)'(push) - (PW + 1)'(pop);
    if (flush_i)
    begin
      next_s.wr = '0;
      next_s.rd = '0;
      next_s.count = '0;
    end
    next_s.full = (next_s.count == (PW + 1)'(DEPTH));
    next_s.empty = (next_s.count == '0);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.empty <= 1'b1;
    end
    else
      s <= next_s;
  end

  // storage has no reset; only words counted as valid are read
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[s.wr] <= in_data_i;
  end

  assign in_ready_o = !s.full;
  assign out_valid_o = !s.empty;
  assign out_data_o = mem[s.rd];

  property p_fifo_count;
    @(posedge clk_i) disable iff (rst_i)
      (push && !pop && !flush_i) |=> (s.count == $past(s.count) + (PW + 1)'(1));
  endproperty
  a_fifo_count: assert property (p_fifo_count)
    else $error("fifo count did not follow a push");
endmodule

// file: logic/flash_cmd_pkg.sv
// shared constants and types for the serial flash command interpreter
package flash_cmd_pkg;

  // system clock rate
  localparam int CLK_MHZ = 50;

  // opcodes handled here
  localparam logic [7:0] OP_WRAP_UPPER = 8'h8d;
  localparam logic [7:0] OP_SET_PARAMS = 8'hc0;
  localparam logic [7:0] OP_QUAD_ON = 8'h38;
  localparam logic [7:0] OP_QUAD_OFF = 8'hff;
  localparam logic [7:0] OP_RST_ENABLE = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_SFDP = 8'h5a;

  // framing: serial clocks per byte and address length
  localparam logic [3:0] CLKS_PER_BYTE_SPI = 4'h8;
  localparam logic [3:0] CLKS_PER_BYTE_QUAD = 4'h2;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;

  // dummy clocks: table table selected by read parameter bits 5:4
  localparam logic [3:0] DUMMY_CLKS [0:3] = '{4'h4, 4'h6, 4'h8, 4'h8};
  localparam logic [3:0] SPI_DUMMY_CLKS = 4'h8;
  localparam logic [3:0] SFDP_DUMMY_CLKS = 4'h8;
  localparam int RD_PARAM_DUMMY_LSB = 4;
  localparam int RD_PARAM_WRAP_LSB = 0;

  // smallest wrap length, doubled per code step
  localparam logic [24:0] WRAP_BASE_BYTES = 25'h0000008;
  localparam logic [24:0] UPPER_HALF_BASE = 25'h1000000;

  // discoverable-parameter header area, byte offsets 00h..17h
  localparam int SFDP_LEN = 24;
  localparam int SFDP_VENDOR_OFS = 16;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] SFDP_ROM [0:23] = '{
    8'h53, 8'h46, 8'h44, 8'h50,  // signature, low byte first
    8'h00, 8'h01, 8'h01, 8'hff,  // revision 1.0, two headers, unused
    8'h00, 8'h00, 8'h01, 8'h09,  // standard table, rev 1.0, nine dwords
    8'h30, 8'h00, 8'h00, 8'hff,  // table pointer 30h, unused
    8'h00, 8'h00, 8'h01, 8'h03,  // maker id slot, rev 1.0, three dwords
    8'h60, 8'h00, 8'h00, 8'hff   // table pointer 60h, unused
  };

  // one-hot command states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CMD = 8'h02,
    ST_ADDR = 8'h04,
    ST_DUMMY = 8'h08,
    ST_DATA_OUT = 8'h10,
    ST_PARAM_IN = 8'h20,
    ST_IGNORE = 8'h40,
    ST_RECOVER = 8'h80
  } cmd_state_t;

  // raw pins as sampled, in sync order
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io;
  } pin_in_t;

  // loads of volatile bits from neighbouring logic
  typedef struct packed {
    logic wel_set;
    logic wel_clr;
    logic sus_set;
    logic sus_clr;
    logic wrap_load;
    logic [2:0] wrap_val;
    logic mode_load;
    logic [7:0] mode_val;
    logic status_load;
    logic [7:0] status_val;
  } volatile_load_t;

  // volatile settings wiped by an accepted reset
  typedef struct packed {
    logic write_permit_latch;
    logic suspend_flag;
    logic [2:0] wrap_setting_bits;
    logic [7:0] continuous_read_mode_byte;
    logic [7:0] volatile_status;
    logic [7:0] read_parameter_byte;
  } volatile_state_t;

endpackage

// file: logic/flash_mode_reset_sfdp_cmd.sv
// command interpreter: upper-half wrapped read, framing switch, reset pair, parameter headers
`timescale 1ns/10ps
// Overview of operation
// - upper wrapped read returns only array bytes 1000000h..1ffffffh.
// - opcode, three address bytes, dummy, data; top address bit forced to one.
// - read address rolls to the wrap block start at its end.
// - wrap length, and dummy clocks in quad framing, come from the last set-parameters byte.
// - enable-quad opcode switches to quad command framing.
// - disable-quad opcode switches back to single-line framing.
// - framing switches keep write latch, suspend and wrap length.
// - accepted reset aborts internal work and restores power-on defaults.
// - accepted reset clears every volatile bit, latch, byte and setting.
// - reset happens only after reset-enable frame followed by reset frame.
// - reset pair is accepted in both framings.
// - during reset recovery every command is ignored.
// - parameter-table read opcode is supported.
// - signature low byte first, then minor revision 0, major 1.
// - header count byte is headers minus one, value one.
// - first header: standard table, rev 1.0, nine dwords, pointer 30h.
// - second header: maker id, rev 1.0, three dwords, pointer 60h.
// - fourth byte of each header's second dword reads all ones.
// - dummy code selects 4, 6, 8 or 8 clocks in quad framing.
// - wrap code selects 8, 16, 32 or 64 bytes.
module flash_mode_reset_sfdp_cmd
#(
  parameter int RESET_RECOVERY_NS = 12000,
  parameter logic [7:0] MAKER_ID = 8'h5e,  // arbitrary value
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_i,                              // system clock, 50 MHz
  input wire logic rst_i,                              // synchronous reset, active high
  input wire logic cs_n_i,                             // chip select pin, active low
  input wire logic sclk_i,                             // serial clock pin
  input wire logic [3:0] io_i,                         // data pins, input side
  output logic [3:0] io_o,                             // data pins, output side
  output logic [3:0] io_oe_n_o,                        // data pin enables, low drives
  input wire flash_cmd_pkg::volatile_load_t vol_load_i, // volatile bit loads
  output flash_cmd_pkg::volatile_state_t vol_o,        // volatile settings
  output logic quad_framing_o,                         // quad command framing active
  output logic abort_o,                                // pulse: abort internal operation
  output logic recovering_o,                           // reset recovery in progress
  output logic [24:0] array_addr_o,                    // array byte address
  output logic array_req_o,                            // array stream wanted
  input wire logic [7:0] array_data_i,                 // array byte
  input wire logic array_valid_i,                      // array byte valid
  output logic array_ready_o                           // fifo room for array byte
);
  import flash_cmd_pkg::*;

  localparam int RECOVER_CYCLES_RAW = (RESET_RECOVERY_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVER_CYCLES = (RECOVER_CYCLES_RAW < 1) ? 1 : RECOVER_CYCLES_RAW;

  typedef struct packed {
    cmd_state_t state;
    logic quad;
    logic rst_armed;
    logic [7:0] shift_in;
    logic [3:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [7:0] opcode;
    logic [15:0] addr;
    logic [1:0] addr_cnt;
    logic [3:0] dummy_cnt;
    logic [7:0] out_shift;
    logic [3:0] out_left;
    logic [3:0] io_out;
    logic [3:0] io_oe_n;
    logic fill_on;
    logic is_sfdp;
    logic array_req;
    logic [24:0] fill_addr;
    volatile_state_t vol;
    logic [15:0] recover_cnt;
    logic recovering;
    logic abort;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;
  pin_in_t pin;
  pin_in_t pin_prev;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [3:0] clks_per_byte;
  logic one_byte_frame;
  logic reset_hit;
  logic fifo_flush;
  logic fifo_in_valid;
  logic [7:0] fifo_in_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_pop;
  logic fill_take;
  logic [7:0] out_byte;
  logic [24:0] wrap_mask;

  // header byte lookup; beyond the header area the table reads erased
  function automatic logic [7:0] sfdp_byte(input logic [24:0] ofs);
    logic [7:0] b;
    b = ERASED_BYTE;
    if (ofs < 25'(SFDP_LEN))
      b = SFDP_ROM[ofs[4:0]];
    if (ofs == 25'(SFDP_VENDOR_OFS))
      b = MAKER_ID;
    return b;
  endfunction

  // low-bit mask of the wrap block for a wrap code
  function automatic logic [24:0] wrap_mask_of(input logic [1:0] code);
    return (WRAP_BASE_BYTES << code) - 25'h1;
  endfunction

  pin_sync #(.W($bits(pin_in_t))) i_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i({cs_n_i, sclk_i, io_i}),
    .sync_o(pin),
    .prev_o(pin_prev)
  );

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) i_byte_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(fifo_flush),
    .in_valid_i(fifo_in_valid),
    .in_data_i(fifo_in_data),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(fifo_pop)
  );

  // pin edges from the synchronised copies only
  assign cs_fall = pin_prev.cs_n && !pin.cs_n;
  assign cs_rise = !pin_prev.cs_n && pin.cs_n;
  assign sclk_rise = !pin_prev.sclk && pin.sclk;
  assign sclk_fall = pin_prev.sclk && !pin.sclk;
  assign clks_per_byte = s.quad ? CLKS_PER_BYTE_QUAD : CLKS_PER_BYTE_SPI;
  assign rx_byte = s.quad ? {s.shift_in[3:0], pin.io} : {s.shift_in[6:0], pin.io[0]};
  assign one_byte_frame = (s.byte_cnt == 2'h1) && (s.bit_cnt == 4'h0);
  assign reset_hit = cs_rise && one_byte_frame && s.rst_armed && (s.opcode == OP_RST)
    && (s.state == ST_IGNORE);
  assign wrap_mask = wrap_mask_of(s.vol.read_parameter_byte[RD_PARAM_WRAP_LSB +: 2]);

  // prefetch stream: array bytes, or header bytes made here; fifo absorbs the rate gap
  assign fifo_in_valid = s.fill_on && (s.is_sfdp || (s.array_req && array_valid_i));
  assign fifo_in_data = s.is_sfdp ? sfdp_byte(s.fill_addr) : array_data_i;
  assign fill_take = fifo_in_valid && fifo_in_ready;

  always_comb
  begin
    next_s = s;
    next_s.abort = 1'b0;
    byte_done = 1'b0;
    fifo_flush = 1'b0;
    fifo_pop = 1'b0;
    out_byte = ERASED_BYTE;
    // volatile loads; a set in the same cycle as a clear wins
    if (vol_load_i.wel_clr)
      next_s.vol.write_permit_latch = 1'b0;
    if (vol_load_i.wel_set)
      next_s.vol.write_permit_latch = 1'b1;
    if (vol_load_i.sus_clr)
      next_s.vol.suspend_flag = 1'b0;
    if (vol_load_i.sus_set)
      next_s.vol.suspend_flag = 1'b1;
    if (vol_load_i.wrap_load)
      next_s.vol.wrap_setting_bits = vol_load_i.wrap_val;
    if (vol_load_i.mode_load)
      next_s.vol.continuous_read_mode_byte = vol_load_i.mode_val;
    if (vol_load_i.status_load)
      next_s.vol.volatile_status = vol_load_i.status_val;
    // advance the fill address; wrap stays inside the aligned block
    if (fill_take)
    begin
      if (s.is_sfdp)
        next_s.fill_addr = s.fill_addr + 25'h1;
      else
        next_s.fill_addr = (s.fill_addr & ~wrap_mask) | ((s.fill_addr + 25'h1) & wrap_mask);
    end
    // byte assembly on rising serial clock in all receiving states
    if (sclk_rise && (s.state == ST_CMD || s.state == ST_ADDR || s.state == ST_PARAM_IN
        || s.state == ST_IGNORE))
    begin
      next_s.shift_in = rx_byte;
      next_s.bit_cnt = s.bit_cnt + 4'h1;
      if (s.bit_cnt + 4'h1 == clks_per_byte)
      begin
        byte_done = 1'b1;
        next_s.bit_cnt = 4'h0;
        if (s.byte_cnt != 2'h3)
          next_s.byte_cnt = s.byte_cnt + 2'h1;
      end
    end
    case (s.state)
      ST_IDLE:
      begin
        if (cs_fall)
        begin
          next_s.state = ST_CMD;
          next_s.bit_cnt = 4'h0;
          next_s.byte_cnt = 2'h0;
          next_s.addr_cnt = 2'h0;
          fifo_flush = 1'b1;
        end
      end
      ST_CMD:
      begin
        if (byte_done)
        begin
          next_s.opcode = rx_byte;
          next_s.state = ST_IGNORE;
          if (rx_byte == OP_WRAP_UPPER || rx_byte == OP_SFDP)
          begin
            next_s.state = ST_ADDR;
            next_s.is_sfdp = (rx_byte == OP_SFDP);
          end
          else if (rx_byte == OP_SET_PARAMS)
            next_s.state = ST_PARAM_IN;
        end
      end
      ST_ADDR:
      begin
        if (byte_done)
        begin
          next_s.addr = {s.addr[7:0], rx_byte};
          next_s.addr_cnt = s.addr_cnt + 2'h1;
          if (s.addr_cnt == ADDR_LAST_BYTE)
          begin
            next_s.state = ST_DUMMY;
            next_s.fill_on = 1'b1;
            if (s.is_sfdp)
            begin
              next_s.fill_addr = {1'b0, s.addr, rx_byte};
              next_s.dummy_cnt = SFDP_DUMMY_CLKS;
            end
            else
            begin
              next_s.fill_addr = UPPER_HALF_BASE | {1'b0, s.addr, rx_byte};
              next_s.dummy_cnt = s.quad
                ? DUMMY_CLKS[s.vol.read_parameter_byte[RD_PARAM_DUMMY_LSB +: 2]]
                : SPI_DUMMY_CLKS;
            end
          end
        end
      end
      ST_DUMMY:
      begin
        if (sclk_rise)
        begin
          next_s.dummy_cnt = s.dummy_cnt - 4'h1;
          if (s.dummy_cnt == 4'h1)
          begin
            next_s.state = ST_DATA_OUT;
            next_s.out_left = 4'h0;
          end
        end
      end
      ST_DATA_OUT:
      begin
        // data changes on falling serial clock; an underrun sends erased bytes
        if (sclk_fall)
        begin
          next_s.io_oe_n = s.quad ? 4'h0 : 4'hd;
          if (s.out_left == 4'h0)
          begin
            fifo_pop = fifo_out_valid;
            if (fifo_out_valid)
              out_byte = fifo_out_data;
            if (s.quad)
            begin
              next_s.io_out = out_byte[7:4];
              next_s.out_shift = {out_byte[3:0], 4'h0};
              next_s.out_left = CLKS_PER_BYTE_QUAD - 4'h1;
            end
            else
            begin
              next_s.io_out = {2'h0, out_byte[7], 1'b0};
              next_s.out_shift = {out_byte[6:0], 1'b0};
              next_s.out_left = CLKS_PER_BYTE_SPI - 4'h1;
            end
          end
          else
          begin
            next_s.io_out = s.quad ? s.out_shift[7:4] : {2'h0, s.out_shift[7], 1'b0};
            next_s.out_shift = s.quad ? {s.out_shift[3:0], 4'h0} : {s.out_shift[6:0], 1'b0};
            next_s.out_left = s.out_left - 4'h1;
          end
        end
      end
      ST_PARAM_IN:
      begin
        if (byte_done)
        begin
          next_s.vol.read_parameter_byte = rx_byte;
          next_s.state = ST_IGNORE;
        end
      end
      ST_IGNORE:
      begin
        next_s.state = ST_IGNORE;
      end
      ST_RECOVER:
      begin
        // chip select edges are not looked at until the count runs out
        if (s.recover_cnt != 16'h0)
          next_s.recover_cnt = s.recover_cnt - 16'h1;
        else if (pin.cs_n)
          next_s.state = ST_IDLE;
      end
      default:
      begin
        next_s.state = ST_IDLE;
      end
    endcase
    // frame end: single-byte commands take effect only on a clean close
    if (cs_rise && s.state != ST_IDLE && s.state != ST_RECOVER)
    begin
      next_s.state = ST_IDLE;
      next_s.fill_on = 1'b0;
      next_s.is_sfdp = 1'b0;
      next_s.io_oe_n = 4'hf;
      next_s.rst_armed = 1'b0;
      fifo_flush = 1'b1;
      if (one_byte_frame && s.state == ST_IGNORE)
      begin
        if (s.opcode == OP_QUAD_ON && !s.quad)
          next_s.quad = 1'b1;
        if (s.opcode == OP_QUAD_OFF && s.quad)
          next_s.quad = 1'b0;
        if (s.opcode == OP_RST_ENABLE)
          next_s.rst_armed = 1'b1;
      end
      if (reset_hit)
      begin
        next_s.vol = '0;
        next_s.quad = 1'b0;
        next_s.abort = 1'b1;
        next_s.state = ST_RECOVER;
        next_s.recover_cnt = 16'(RECOVER_CYCLES);
      end
    end
    next_s.array_req = next_s.fill_on && !next_s.is_sfdp;
    next_s.recovering = (next_s.state == ST_RECOVER);
  end

  // single state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.state <= ST_IDLE;
      s.io_oe_n <= 4'hf;
    end
    else
      s <= next_s;
  end

  assign io_o = s.io_out;
  assign io_oe_n_o = s.io_oe_n;
  assign vol_o = s.vol;
  assign quad_framing_o = s.quad;
  assign abort_o = s.abort;
  assign recovering_o = s.recovering;
  assign array_addr_o = s.fill_addr;
  assign array_req_o = s.array_req;
  assign array_ready_o = fifo_in_ready;

  property p_upper_half;
    @(posedge clk_i) disable iff (rst_i)
      s.array_req |-> s.fill_addr[24];
  endproperty
  a_upper_half: assert property (p_upper_half)
    else $error("array read left the upper half");

  property p_wrap_block;
    @(posedge clk_i) disable iff (rst_i)
      (fill_take && s.array_req && !fifo_flush && !cs_rise) |=>
        ((s.fill_addr ^ $past(s.fill_addr)) & ~$past(wrap_mask)) == 25'h0;
  endproperty
  a_wrap_block: assert property (p_wrap_block)
    else $error("read address left its wrap block");

  property p_quad_on;
    @(posedge clk_i) disable iff (rst_i)
      (cs_rise && one_byte_frame && s.state == ST_IGNORE && s.opcode == OP_QUAD_ON) |=> s.quad;
  endproperty
  a_quad_on: assert property (p_quad_on)
    else $error("enable-quad did not switch framing");

  property p_quad_off;
    @(posedge clk_i) disable iff (rst_i)
      (cs_rise && one_byte_frame && s.state == ST_IGNORE && s.opcode == OP_QUAD_OFF) |=> !s.quad;
  endproperty
  a_quad_off: assert property (p_quad_off)
    else $error("disable-quad did not restore framing");

  property p_switch_keeps;
    @(posedge clk_i) disable iff (rst_i)
      ($changed(s.quad) && !s.abort) |->
        (s.vol.read_parameter_byte == $past(s.vol.read_parameter_byte))
        && (s.vol.write_permit_latch == ($past(s.vol.write_permit_latch) || $past(vol_load_i.wel_set))
            || $past(vol_load_i.wel_clr));
  endproperty
  a_switch_keeps: assert property (p_switch_keeps)
    else $error("framing switch disturbed settings");

  property p_reset_clears;
    @(posedge clk_i) disable iff (rst_i)
      reset_hit |=> (s.vol == '0) && s.abort && !s.quad ##1 !s.abort;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("reset left volatile state or abort wrong");

  property p_reset_needs_pair;
    @(posedge clk_i) disable iff (rst_i)
      $rose(s.abort) |-> $past(s.rst_armed) && ($past(s.opcode) == OP_RST);
  endproperty
  a_reset_needs_pair: assert property (p_reset_needs_pair)
    else $error("reset without enable frame");

  property p_recover_ignores;
    @(posedge clk_i) disable iff (rst_i)
      (s.state == ST_RECOVER && s.recover_cnt != 16'h0) |=> s.state == ST_RECOVER;
  endproperty
  a_recover_ignores: assert property (p_recover_ignores)
    else $error("command taken during recovery");

  property p_signature;
    @(posedge clk_i) disable iff (rst_i)
      (fill_take && s.is_sfdp && s.fill_addr == 25'h0) |-> fifo_in_data == SFDP_ROM[0];
  endproperty
  a_signature: assert property (p_signature)
    else $error("signature byte wrong");
endmodule

// file: logic/pin_sync.sv
// two-stage synchroniser for pin inputs plus a delayed copy for edge finding
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 6
) (
  input wire logic clk_i,          // system clock
  input wire logic rst_i,          // synchronous reset, active high
  input wire logic [W-1:0] raw_i,  // asynchronous pin levels
  output logic [W-1:0] sync_o,     // synchronised level
  output logic [W-1:0] prev_o      // synchronised level one cycle older
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prev;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // meta feeds only the stable stage; edges come from stable vs prev
  always_comb
  begin
    next_s.meta = raw_i;
    next_s.stable = s.meta;
    next_s.prev = s.stable;
  end

  // reset value all ones: chip select idles high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '1;
    else
      s <= next_s;
  end

  assign sync_o = s.stable;
  assign prev_o = s.prev;
endmodule

// file: tb/flash_host_model.sv
// host controller model: chip select, serial clock and data pins
`timescale 1ns/10ps
module flash_host_model (
  input wire logic clk_i,      // system clock
  input wire logic [3:0] io_i, // device data out
  output logic cs_n_o,         // chip select
  output logic sclk_o,         // serial clock, still between frames
  output logic [3:0] io_o      // data to device
);
  initial {cs_n_o, sclk_o, io_o} = 6'h25;
  // 80 ns half period, launched just after a clock edge
  task half();
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  // one byte msb first, reply sampled on each rise
  task xfer(input logic [7:0] b, input logic q, output logic [7:0] r);
    for (int i = 7; i >= 0; i = i - (q ? 4 : 1))
    begin
      sclk_o = 1'b0;
      io_o = q ? b[i-:4] : {~io_o[3:1], b[i]};
      half();
      sclk_o = 1'b1;
      r = q ? {r[3:0], io_i} : {r[6:0], io_i[1]};
      half();
    end
  endtask
  // released pins flip so no stale value survives
  task frame(input logic on);
    sclk_o = 1'b0;
    cs_n_o = ~on;
    if (!on)
      io_o = ~io_o;
    half();
    half();
  endtask
endmodule

// file: tb/flash_mode_reset_sfdp_cmd_bench.sv
// self-checking bench for the flash command interpreter
`timescale 1ns/10ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module flash_mode_reset_sfdp_cmd_bench;
  import flash_cmd_pkg::*;
  localparam logic [7:0] MID = 8'h3c; // arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic avalid = 1'b0;
  logic [7:0] adata = 8'h00;
  logic cs_n, sclk, aready, quad, abort, rec, req;
  logic [3:0] hio, dio, oe_n;
  logic [24:0] addr;
  volatile_load_t vload = '0;
  volatile_state_t vol;
  int errors = 0;
  int cmp_count = 0;
  int aborts = 0;
  always #10 clk_i = ~clk_i;
  // undriven data pins read inverted, so a stale value cannot pass
  flash_host_model h (.clk_i(clk_i), .io_i(dio ^ oe_n), .cs_n_o(cs_n), .sclk_o(sclk), .io_o(hio));
  flash_mode_reset_sfdp_cmd #(.RESET_RECOVERY_NS(4000), .MAKER_ID(MID), .FIFO_DEPTH(8))
    i_flash_mode_reset_sfdp_cmd (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .io_i(hio), .io_o(dio), .io_oe_n_o(oe_n), .vol_load_i(vload), .vol_o(vol),
    .quad_framing_o(quad), .abort_o(abort), .recovering_o(rec), .array_addr_o(addr),
    .array_req_o(req), .array_data_i(adata), .array_valid_i(avalid), .array_ready_o(aready));
  // array answers with its low address byte; abort pulses counted
  always @(posedge clk_i)
  begin
    #1;
    avalid = req;
    adata = addr[7:0];
    aborts = aborts + (abort === 1'b1);
  end
  task test_done();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one-cycle load of volatile bits, launched just after an edge
  task pulse(input volatile_load_t v);
    @(posedge clk_i);
    #1;
    vload = v;
    @(posedge clk_i);
    #1;
    vload = '0;
  endtask
  task cmd(input logic [7:0] op, input logic q);
    logic [7:0] r;
    h.frame(1'b1);
    h.xfer(op, q, r);
    h.frame(1'b0);
  endtask
  task t_sfdp();
    logic [7:0] r;
    h.frame(1'b1);
    h.xfer(OP_SFDP, 1'b0, r);
    repeat (4) h.xfer(8'h00, 1'b0, r);
    for (int i = 0; i < SFDP_LEN; i++)
    begin
      h.xfer(8'h00, 1'b0, r);
      `CHK("table byte", (i == SFDP_VENDOR_OFS) ? MID : SFDP_ROM[i], r)
    end
    `CHK("read enables", 4'hd, oe_n)
    h.frame(1'b0);
    `CHK("released enables", 4'hf, oe_n)
    `CHK("fifo room", 1'b1, aready)
  endtask
  task t_quad();
    pulse('{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 3'h5, 1'b1, 8'ha5, 1'b1, 8'h3c});
    for (int k = 0; k < 3; k++)
    begin
      cmd(k[0] ? OP_QUAD_OFF : OP_QUAD_ON, k[0]);
      `CHK("framing", ~k[0], quad)
      `CHK("kept", 5'h1d, {vol.write_permit_latch, vol.suspend_flag, vol.wrap_setting_bits})
    end
  endtask
  task t_wrap(input logic q, input logic [7:0] p, input int nd);
    logic [7:0] r;
    logic [7:0] m;
    m = (8'h08 << p[1:0]) - 8'h01;
    cmd(OP_SET_PARAMS, q);
    h.frame(1'b1);
    h.xfer(OP_SET_PARAMS, q, r);
    h.xfer(p, q, r);
    h.frame(1'b0);
    h.frame(1'b1);
    h.xfer(OP_WRAP_UPPER, q, r);
    for (int i = 0; i < 3; i++)
      h.xfer((i == 2) ? 8'h1e : 8'h00, q, r);
    repeat (nd) h.xfer(8'h00, q, r);
    for (int i = 0; i < 4; i++)
    begin
      h.xfer(8'h00, q, r);
      `CHK("wrap byte", (8'h1e & ~m) | ((8'h1e + i[7:0]) & m), r)
    end
    `CHK("top address bit", 1'b1, addr[24])
    `CHK("drive enables", q ? 4'h0 : 4'hd, oe_n)
    h.frame(1'b0);
  endtask
  task t_reset();
    // host leaves no suspended work before resetting; latch set beats its clear
    pulse('{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0, 8'h00});
    `CHK("latch and suspend", 2'h2, {vol.write_permit_latch, vol.suspend_flag})
    cmd(OP_RST, 1'b1);
    `CHK("lone reset", 0, aborts)
    cmd(OP_RST_ENABLE, 1'b1);
    cmd(OP_RST, 1'b1);
    `CHK("abort pulses", 1, aborts)
    `CHK("volatile", 29'h0, vol)
    `CHK("recovering", 1'b1, rec)
    cmd(OP_QUAD_ON, 1'b0);
    `CHK("ignored", 1'b0, quad)
    for (int k = 0; k < 400 && rec !== 1'b0; k++)
      @(posedge clk_i);
    `CHK("recovery end", 1'b0, rec)
    if (rec !== 1'b0)
      test_done();
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    t_sfdp();
    t_quad();
    t_wrap(1'b1, 8'h01, 2);
    t_reset();
    t_wrap(1'b0, 8'h02, 1);
    test_done();
  end
  // hang guard
  initial
  begin
    #1000000;
    errors++;
    test_done();
  end
endmodule
